// *** hdl/tmz_timer.sv ***
// Eight-bit timer/counter with AHB-Lite registers and shared prescaler
// How it works
// - Eight-bit count register, software readable/writable
// - Timer mode counts each instruction cycle
// - Count write holds increments two cycles
// - Counter mode counts external input edges
// - Prescaler serves timer or watchdog only
// - Eight timer ratios, 1:2 to 1:256
// - Undivided rate only when prescaler on watchdog
// - Prescaler count hidden from software
// - Count write clears timer-assigned prescaler
// - Watchdog clear clears watchdog-assigned prescaler
// - Rollover to zero sets overflow flag
// - Interrupt only when overflow enable set
// - Sleep freezes the counter
// - External input synchronized on Q2/Q4 only when prescaler on timer
`timescale 1ns/10ps
`include "tmz_consts.svh"
module tmz_timer (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic EXT_COUNT_INPUT,
    output logic IRQ,
    output logic [7:0] TIMER_COUNT_VALUE,
    output logic PRESCALE_TO_WATCHDOG
);
    import tmz_pkg::*;
    // ----------------------------------------------------------------
    // Phase clocks
    // ----------------------------------------------------------------
    tmz_phase_t phase;
    logic q2_pulse;
    logic q4_pulse;
    tmz_phase u_phase (
        .CORE_CLK(CORE_CLK),
        .SYS_RST(SYS_RST),
        .phase(phase),
        .q2_pulse(q2_pulse),
        .q4_pulse(q4_pulse)
    );
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    tmz_opt_t opt_ff;
    tmz_opt_t nxt_opt;
    logic ovf_ff;
    logic nxt_ovf;
    logic ovf_en_ff;
    logic nxt_ovf_en;
    logic sleep_ff;
    logic nxt_sleep;
    logic [1:0] hold_ff;
    logic [1:0] nxt_hold;
    logic ext_ff;
    logic ext_prev_ff;
    logic pre_q2_ff;
    logic pre_sync_ff;
    logic pre_sync_prev_ff;
    logic irq_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    tmz_req_t req_ff;
    logic req_valid_ff;
    // ----------------------------------------------------------------
    // AHB-Lite address phase capture
    // ----------------------------------------------------------------
    wire addr_take = HSEL & HREADY & HTRANS[1];
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            req_valid_ff <= 1'b0;
            req_ff <= '0;
        end else begin
            req_valid_ff <= addr_take;
            req_ff <= addr_take ? tmz_req_t'({HADDR[11:0], HWRITE}) : req_ff;
        end
    end
    // Data phase decode
    wire wr = req_valid_ff & req_ff.write;
    wire wr_count = wr & (req_ff.addr == `TMZ_ADDR_COUNT);
    wire wr_opt = wr & (req_ff.addr == `TMZ_ADDR_OPTION);
    wire wr_en = wr & (req_ff.addr == `TMZ_ADDR_IRQ_EN);
    wire wr_clr = wr & (req_ff.addr == `TMZ_ADDR_IRQ_CLR);
    wire wr_ctrl = wr & (req_ff.addr == `TMZ_ADDR_CTRL);
    wire wdt_clear = wr_ctrl & HWDATA[`TMZ_CTRL_WDTCLR_BIT];
    // ----------------------------------------------------------------
    // Count source and prescaler
    // ----------------------------------------------------------------
    wire prescaler_assign_bit = opt_ff.prescaler_assign_bit;
    wire cycle_tick = q4_pulse & ~sleep_ff;
    // Counter mode: edge on the external input, polarity by edge select
    wire ext_rise = ext_ff & ~ext_prev_ff;
    wire ext_fall = ~ext_ff & ext_prev_ff;
    wire ext_edge = opt_ff.edge_sel ? ext_fall : ext_rise;
    wire src_tick = opt_ff.src_sel ? ext_edge : cycle_tick;
    // Prescaler cleared by count writes on timer, by watchdog clear otherwise
    wire pre_clear = prescaler_assign_bit ? wdt_clear : wr_count;
    logic pre_out;
    tmz_prescaler u_pre (
        .CORE_CLK(CORE_CLK),
        .SYS_RST(SYS_RST),
        .tick(src_tick & ~sleep_ff),
        .clear(pre_clear),
        .ratio(opt_ff.ratio),
        .out_bit(pre_out)
    );
    // Prescaler output sampled on Q2, passed on at Q4 in counter mode
    wire pre_rise = pre_sync_ff & ~pre_sync_prev_ff;
    wire pre_edge_cnt = pre_rise & q4_pulse;
    // Prescaler rising edge in timer mode appears once per full period
    wire pre_edge_tmr = pre_out & ~pre_sync_prev_ff & cycle_tick;
    wire pre_tick = opt_ff.src_sel ? pre_edge_cnt : pre_edge_tmr;
    // Watchdog-assigned prescaler leaves the timer at 1:1
    wire inc_req = prescaler_assign_bit ? src_tick : pre_tick;
    wire inc = inc_req & ~sleep_ff & (hold_ff == 2'h0) & ~wr_count;
    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    assign nxt_count = wr_count ? HWDATA[7:0] : (inc ? count_ff + 8'h01 : count_ff);
    wire rollover = inc & (count_ff == 8'hff);
    // Hold counts instruction cycles after a count write
    assign nxt_hold = wr_count ? 2'(`TMZ_WRITE_HOLD) :
        ((hold_ff != 2'h0) && cycle_tick ? hold_ff - 2'h1 : hold_ff);
    assign nxt_opt = wr_opt ? tmz_opt_t'(HWDATA[7:0]) : opt_ff;
    // Set wins over clear on the same cycle
    assign nxt_ovf = rollover | (ovf_ff & ~(wr_clr & HWDATA[0]));
    assign nxt_ovf_en = wr_en ? HWDATA[0] : ovf_en_ff;
    assign nxt_sleep = wr_ctrl ? HWDATA[`TMZ_CTRL_SLEEP_BIT] : sleep_ff;
    // ----------------------------------------------------------------
    // Read mux; prescaler count has no address
    // ----------------------------------------------------------------
    wire rd_take = addr_take & ~HWRITE;
    wire [11:0] rd_addr = HADDR[11:0];
    assign nxt_rdata = !rd_take ? rdata_ff :
        (rd_addr == `TMZ_ADDR_COUNT) ? {24'h000000, nxt_count} :
        (rd_addr == `TMZ_ADDR_OPTION) ? {24'h000000, nxt_opt} :
        (rd_addr == `TMZ_ADDR_STATUS) ? {31'h00000000, nxt_ovf} :
        (rd_addr == `TMZ_ADDR_IRQ_EN) ? {31'h00000000, nxt_ovf_en} :
        (rd_addr == `TMZ_ADDR_CTRL) ? {31'h00000000, nxt_sleep} :
        32'h00000000;
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            count_ff <= `TMZ_COUNT_RESET;
            opt_ff <= tmz_opt_t'(`TMZ_OPT_RESET);
            ovf_ff <= 1'b0;
            ovf_en_ff <= 1'b0;
            sleep_ff <= 1'b0;
            hold_ff <= 2'h0;
            rdata_ff <= 32'h00000000;
        end else begin
            count_ff <= nxt_count;
            opt_ff <= nxt_opt;
            ovf_ff <= nxt_ovf;
            ovf_en_ff <= nxt_ovf_en;
            sleep_ff <= nxt_sleep;
            hold_ff <= nxt_hold;
            rdata_ff <= nxt_rdata;
        end
    end
    // Input and prescaler sampling; the Q2 sampler feeds only the Q4 sampler
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ext_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
            pre_q2_ff <= 1'b0;
            pre_sync_ff <= 1'b0;
            pre_sync_prev_ff <= 1'b0;
        end else begin
            ext_ff <= EXT_COUNT_INPUT;
            ext_prev_ff <= ext_ff;
            pre_q2_ff <= q2_pulse ? pre_out : pre_q2_ff;
            pre_sync_ff <= q4_pulse ? pre_q2_ff : pre_sync_ff;
            pre_sync_prev_ff <= opt_ff.src_sel ? (q4_pulse ? pre_sync_ff : pre_sync_prev_ff) :
                (cycle_tick ? pre_out : pre_sync_prev_ff);
        end
    end
    // Interrupt level from the enabled overflow flag
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_ovf & nxt_ovf_en;
        end
    end
    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign HRDATA = rdata_ff;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign IRQ = irq_ff;
    assign TIMER_COUNT_VALUE = count_ff;
    assign PRESCALE_TO_WATCHDOG = opt_ff.prescaler_assign_bit;
endmodule

// *** hdl/tmz_consts.svh ***
// Constants for the eight-bit timer with shared prescaler
`ifndef TMZ_CONSTS_SVH
`define TMZ_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TMZ_ADDR_COUNT 12'h000
`define TMZ_ADDR_OPTION 12'h004
`define TMZ_ADDR_STATUS 12'h008
`define TMZ_ADDR_IRQ_EN 12'h00c
`define TMZ_ADDR_IRQ_CLR 12'h010
`define TMZ_ADDR_CTRL 12'h014
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TMZ_OPT_SRC_BIT 5
`define TMZ_OPT_EDGE_BIT 4
`define TMZ_OPT_PSA_BIT 3
`define TMZ_OPT_RESET 8'hff
`define TMZ_COUNT_RESET 8'h00
`define TMZ_CTRL_SLEEP_BIT 0
`define TMZ_CTRL_WDTCLR_BIT 1
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TMZ_QDIV 4
`define TMZ_WRITE_HOLD 2
`endif

// *** hdl/tmz_pkg.sv ***
// Types for the eight-bit timer with shared prescaler
package tmz_pkg;
    // Option word: bit 5 source, bit 4 edge, bit 3 assignment, bits 2:0 ratio
    typedef struct packed {
        logic [1:0] rsvd;
        logic src_sel;
        logic edge_sel;
        logic prescaler_assign_bit;
        logic [2:0] ratio;
    } tmz_opt_t;
    typedef enum logic [1:0] {
        TMZ_Q1 = 2'b00,
        TMZ_Q2 = 2'b01,
        TMZ_Q3 = 2'b10,
        TMZ_Q4 = 2'b11
    } tmz_phase_t;
    typedef struct packed {
        logic [11:0] addr;
        logic write;
    } tmz_req_t;
endpackage

// *** hdl/tmz_phase.sv ***
// Instruction cycle phase generator
`timescale 1ns/10ps
`include "tmz_consts.svh"
module tmz_phase (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    output tmz_pkg::tmz_phase_t phase,
    output logic q2_pulse,
    output logic q4_pulse
);
    import tmz_pkg::*;
    tmz_phase_t phase_ff;
    tmz_phase_t nxt_phase;
    // Next phase and decoded phase strobes
    assign nxt_phase = tmz_phase_t'(phase_ff + 2'h1);
    assign phase = phase_ff;
    assign q2_pulse = (phase_ff == TMZ_Q2);
    assign q4_pulse = (phase_ff == TMZ_Q4);
    // Four phases per instruction cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            phase_ff <= TMZ_Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end
endmodule

// *** hdl/tmz_prescaler.sv ***
// Shared eight-bit prescaler with ratio select
`timescale 1ns/10ps
`include "tmz_consts.svh"
module tmz_prescaler (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic tick,
    input wire logic clear,
    input wire logic [2:0] ratio,
    output logic out_bit
);
    import tmz_pkg::*;
    logic [7:0] pre_ff;
    logic [7:0] nxt_pre;
    // Hidden count; no software path reads or writes it
    assign nxt_pre = clear ? 8'h00 : (tick ? pre_ff + 8'h01 : pre_ff);
    // Bit n toggles at 1:2^(n+1), so its level is the divided clock
    assign out_bit = pre_ff[ratio];
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pre_ff <= 8'h00;
        end else begin
            pre_ff <= nxt_pre;
        end
    end
endmodule

// *** testbench/tmz_pin_model.sv ***
// Model of the external count pin driven by the far side
`timescale 1ns/10ps
module tmz_pin_model (
    input wire logic clk,
    output logic pin
);
    initial pin = 1'b0;
    // Toggles the pin, each level held 8 clocks so the phase sampling sees it
    task toggles(input int n);
        repeat (n) begin
            @(posedge clk);
            pin <= ~pin;
            repeat (7) @(posedge clk);
        end
    endtask
endmodule

// *** testbench/tmz_timer_props.sv ***
// Port checker for the eight-bit timer
`timescale 1ns/10ps
module tmz_timer_props (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic IRQ,
    input wire logic [7:0] TIMER_COUNT_VALUE,
    input wire logic PRESCALE_TO_WATCHDOG
);
    logic wa_ff, en_ff, slp_ff;
    logic [11:0] aa_ff;
    logic [7:0] opt_ff;
    wire wc = wa_ff && aa_ff == 12'h000;
    wire wclr = wa_ff && aa_ff == 12'h010 && HWDATA[0];
    // Shadows of the option, enable and sleep registers that software writes
    always_ff @(posedge CORE_CLK) begin
        wa_ff <= !SYS_RST && HSEL && HREADY && HTRANS[1] && HWRITE;
        aa_ff <= (HSEL && HREADY && HTRANS[1]) ? HADDR[11:0] : aa_ff;
        if (SYS_RST) begin
            opt_ff <= 8'hff;
            en_ff <= 1'b0;
            slp_ff <= 1'b0;
        end else if (wa_ff) begin
            if (aa_ff == 12'h004) opt_ff <= HWDATA[7:0];
            if (aa_ff == 12'h00c) en_ff <= HWDATA[0];
            if (aa_ff == 12'h014) slp_ff <= HWDATA[0];
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    count_step_a: assert property ($changed(TIMER_COUNT_VALUE) && !$past(wc) |->
        TIMER_COUNT_VALUE == $past(TIMER_COUNT_VALUE) + 8'h01) else $error("count jumped");
    write_hold_a: assert property ($past(wc) |-> ##1 $stable(TIMER_COUNT_VALUE) [*4])
        else $error("count moved right after a write");
    psa_port_a: assert property (PRESCALE_TO_WATCHDOG == opt_ff[3])
        else $error("assignment output differs from option");
    sleep_hold_a: assert property ($past(slp_ff, 2) && slp_ff && !$past(wc) |->
        $stable(TIMER_COUNT_VALUE)) else $error("count moved in sleep");
    ovf_irq_a: assert property ($past(TIMER_COUNT_VALUE) == 8'hff && TIMER_COUNT_VALUE == 8'h00
        && !$past(wc) && en_ff && $past(en_ff) |-> ##[0:2] IRQ) else $error("no irq on rollover");
    irq_mask_a: assert property (IRQ |-> en_ff) else $error("irq while disabled");
    irq_hold_a: assert property ($fell(IRQ) |-> $past(wclr) || !en_ff)
        else $error("irq dropped without clear");
    rd_upper_a: assert property (HRDATA[31:8] == 24'h0) else $error("upper read bits set");
endmodule
bind tmz_timer tmz_timer_props u_props (.*);

// *** testbench/tb.sv ***
// Self-checking bench for the eight-bit timer
`timescale 1ns/10ps
module tb;
    logic clk = 0, rst = 1, hsel = 1, hwrite = 0, ext, hready, hresp, irq, prescaler_assign_bit;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [7:0] cnt, v;
    int failures = 0, tests_run = 0, seed = 8593, n, r;
    tmz_timer dut (.CORE_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .EXT_COUNT_INPUT(ext), .IRQ(irq),
        .TIMER_COUNT_VALUE(cnt), .PRESCALE_TO_WATCHDOG(prescaler_assign_bit));
    tmz_pin_model pm (.clk(clk), .pin(ext));
    initial forever #5 clk = ~clk;
    task tally_and_finish;
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One AHB-Lite single transfer, address phase then data phase
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    // Edges until the count moves
    task wchg(output int k);
        #1;
        v = cnt;
        for (k = 0; k < 3000 && cnt === v; k++) @(posedge clk) #1;
        chk("count wait", k < 3000, 1);
    endtask
    initial begin
        #400us;
        chk("watchdog", 0, 1);
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(12'h000, 0, "count");
        rd(12'h004, 8'hff, "option");
        rd(12'h008, 0, "status");
        rd(12'h010, 0, "clear reg");
        wr(12'h0f0, 32'h5a);
        rd(12'h0f0, 0, "unmapped");
        wr(12'h004, 8'h08);
        rd(12'h004, 8'h08, "option");
        r = $random(seed) & 8'hff;
        wr(12'h000, r);
        wchg(n);
        chk("hold", n > 4 && n <= 12, 1);
        chk("tick", cnt, 8'(r + 1));
        repeat (40) @(posedge clk);
        #1 chk("rate", cnt, 8'(r + 11));
        wr(12'h014, 1);
        repeat (2) @(posedge clk);
        #1 v = cnt;
        repeat (40) @(posedge clk);
        chk("sleep", cnt, v);
        wr(12'h014, 0);
        wr(12'h00c, 1);
        wr(12'h000, 8'hfe);
        for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
        chk("irq", irq, 1);
        rd(12'h008, 1, "status");
        wr(12'h010, 1);
        rd(12'h008, 0, "status");
        chk("irq", irq, 0);
        wr(12'h00c, 0);
        wr(12'h000, 8'hfe);
        repeat (30) @(posedge clk);
        chk("masked irq", irq, 0);
        rd(12'h008, 1, "status");
        wr(12'h00c, 1);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        wr(12'h010, 1);
        wr(12'h00c, 0);
        wr(12'h014, 2);
        for (r = 0; r < 8; r++) begin
            wr(12'h004, r);
            wr(12'h000, 0);
            wchg(n);
            v = cnt;
            repeat (16 << r) @(posedge clk);
            #1 chk("prescaled", cnt, 8'(v + 2));
        end
        chk("assign", prescaler_assign_bit, 0);
        // Hand the prescaler to the watchdog in the safe order
        wr(12'h014, 2);
        wr(12'h000, 0);
        wr(12'h004, 8'h08);
        wr(12'h014, 2);
        chk("assign", prescaler_assign_bit, 1);
        for (r = 0; r < 3; r++) begin
            wr(12'h004, r == 2 ? 8'h20 : 8'h28 | (r << 4));
            v = 8'($random(seed));
            wr(12'h000, v);
            repeat (12) @(posedge clk);
            pm.toggles(r == 2 ? 8 : 5);
            repeat (8) @(posedge clk);
            #1 chk("counter", cnt, 8'(v + (r == 2 ? 2 : 3)));
        end
        tally_and_finish;
    end
endmodule
